// >>> hdl/duplex_switchback_map.vh
`ifndef DUPLEX_SWITCHBACK_MAP_VH
`define DUPLEX_SWITCHBACK_MAP_VH

// ----------------------------------------------------------------------
// Timing base
// ----------------------------------------------------------------------
// Clock period of i_sys_clk in ns
`define CLK_PERIOD_NS 10
// One position step is this long in ns
`define STEP_TIME_NS 100000
// Width of the step divider count
`define STEP_DIV_W 14
// Width of a step target count
`define STEP_W 8

// ----------------------------------------------------------------------
// Sheet length, in units of 0.1 mm
// ----------------------------------------------------------------------
`define LEN_W 13
// Lower limit of two-sheet circulation
`define LEN_MIN_DMM 13'h0_71C
// Boundary between two-sheet and one-sheet circulation
`define LEN_SPLIT_DMM 13'h0_86F
// Upper limit of one-sheet circulation
`define LEN_MAX_DMM 13'h1_0DE

// ----------------------------------------------------------------------
// Exit/switchback path states
// ----------------------------------------------------------------------
`define EX_W 3
`define EX_IDLE 3'h0
`define EX_EJECT 3'h1
`define EX_TO_REV 3'h2
`define EX_REVERSE 3'h3
`define EX_HANDOFF 3'h4

// ----------------------------------------------------------------------
// Incoming duplex transport states
// ----------------------------------------------------------------------
`define DP_W 3
`define DP_IDLE 3'h0
`define DP_WAIT_START 3'h1
`define DP_TO_FIRST 3'h2
`define DP_TO_SECOND 3'h3
`define DP_TO_STOP 3'h4

`endif

// >>> hdl/position_counter.v
`timescale 1ns/1ns
`include "duplex_switchback_map.vh"

// Counts position steps from a start pulse and flags the target once.
module position_counter (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Control
  input wire i_start,
  input wire i_tick,
  input wire [`STEP_W-1:0] i_target,
  // Result
  output reg o_done
);

  // Steps seen since start
  reg [`STEP_W-1:0] count_reg;
  // Count is running
  reg busy_reg;
  // Next count, kept at target width on purpose
  wire [`STEP_W-1:0] count_inc;

  assign count_inc = count_reg + {{(`STEP_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // Step counting
  // ----------------------------------------------------------------------
  // A restart while busy starts over; a zero target ends on the first
  // step, so the position is never reached early.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= {`STEP_W{1'b0}};
      busy_reg <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        count_reg <= {`STEP_W{1'b0}};
        busy_reg <= 1'b1;
      end else if (busy_reg && i_tick) begin
        count_reg <= count_inc;
        // Target reached on this step
        if (count_inc >= i_target) begin
          busy_reg <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule // position_counter

// >>> hdl/duplex_switchback_sequencer.v
// What this block does
// - Single-sided: switchback roller forward, eject sheet.
// - Second-side pass: eject forward like single-sided.
// - First-side pass in a supported length: forward, then reverse at position.
// - Reversed sheet at position: start duplex motor.
// - One motor drives all three duplex rollers.
// - First duplex sensor catches leading edge.
// - Second duplex sensor catches leading edge.
// - Past second sensor plus distance: stop, hold.
// - Scheduled feed time: restart motor, re-feed.
// - Pick one- or two-sheet circulation by length.
// - One-sheet: even page first, odd on reverse.
// - One-sheet: repeat cycle until job ends.
// - Two-sheet: feed next blank during reversal.
// - Two-sheet: held sheet waits for next print.
// - Two-sheet: next reversal starts held sheet re-feed.
// - Two-sheet: repeat steady-state cycle.
`timescale 1ns/1ns
`include "duplex_switchback_map.vh"

module duplex_switchback_sequencer #(
  // Clock cycles per position step; shorten in simulation
  parameter STEP_CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Job control from the print scheduler
  input wire i_job_start,
  input wire i_job_end,
  input wire i_two_sided,
  input wire i_second_side,
  input wire [`LEN_W-1:0] i_sheet_len_dmm,
  input wire i_refeed_time,
  // Paper sensors, high while paper is present
  input wire i_exit_sensor,
  input wire i_duplex_path_sensor_first,
  input wire i_duplex_path_sensor_second,
  // Set positions in steps
  input wire [`STEP_W-1:0] i_reverse_steps,
  input wire [`STEP_W-1:0] i_motor_start_steps,
  input wire [`STEP_W-1:0] i_stop_steps,
  input wire [`STEP_W-1:0] i_refeed_steps,
  // Motor drives
  output reg o_switchback_roller_motor_on,
  output reg o_switchback_roller_motor_reverse,
  output reg o_duplex_transport_motor_on,
  // Status and requests to the scheduler
  output reg o_job_active,
  output reg o_two_sheet_mode,
  output reg o_length_unsupported,
  output reg o_print_even_page,
  output reg o_feed_next_sheet,
  output reg o_sheet_held,
  output reg o_refeed_started,
  output reg o_duplex_jam
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  // Step divider count and its one-cycle enable
  reg [`STEP_DIV_W-1:0] div_reg;
  reg step_tick_reg;
  // Previous sensor levels for edge detection
  reg exit_prev_reg;
  reg first_prev_reg;
  reg second_prev_reg;
  // Exit path and incoming duplex states
  reg [`EX_W-1:0] ex_state_reg;
  reg [`EX_W-1:0] ex_state_next;
  reg [`DP_W-1:0] dp_state_reg;
  reg [`DP_W-1:0] dp_state_next;
  // A sheet sits at the re-feed position
  reg held_reg;
  // Held sheet is being delivered to registration
  reg refeed_reg;
  // Sensor leading edges and the exit sensor trailing edge
  wire exit_rise;
  wire exit_fall;
  wire first_rise;
  wire second_rise;
  // Counter starts and completions
  wire rev_start;
  wire rev_done;
  wire mstart_start;
  wire mstart_done;
  wire stop_start;
  wire stop_done;
  wire refeed_go;
  wire refeed_done;
  // Duplex motor demand from the incoming sheet
  wire incoming_run;
  // Sheet arrives while a held sheet cannot move away
  wire collide;

  assign exit_rise = i_exit_sensor & ~exit_prev_reg;
  assign exit_fall = ~i_exit_sensor & exit_prev_reg;
  assign first_rise = i_duplex_path_sensor_first & ~first_prev_reg;
  assign second_rise = i_duplex_path_sensor_second & ~second_prev_reg;

  assign rev_start = (ex_state_reg == `EX_TO_REV) & rev_done;
  assign mstart_start = rev_start;
  assign stop_start = (dp_state_reg == `DP_TO_SECOND) & second_rise;
  assign refeed_go = held_reg & ~refeed_reg &
    (i_refeed_time | (o_two_sheet_mode & rev_start));
  assign incoming_run = (dp_state_reg == `DP_TO_FIRST) |
    (dp_state_reg == `DP_TO_SECOND) | (dp_state_reg == `DP_TO_STOP);
  // Held sheet not leaving while the next one would reach it
  assign collide = held_reg & ~refeed_go & ~refeed_reg & stop_start;

  // ----------------------------------------------------------------------
  // Position counters
  // ----------------------------------------------------------------------
  // From exit sensor edge to the switchback point
  position_counter u_rev_cnt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(exit_rise),
    .i_tick(step_tick_reg),
    .i_target(i_reverse_steps),
    .o_done(rev_done)
  );

  // From reversal to duplex motor start
  position_counter u_mstart_cnt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(mstart_start),
    .i_tick(step_tick_reg),
    .i_target(i_motor_start_steps),
    .o_done(mstart_done)
  );

  // From second sensor edge to the re-feed position
  position_counter u_stop_cnt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(stop_start),
    .i_tick(step_tick_reg),
    .i_target(i_stop_steps),
    .o_done(stop_done)
  );

  // Run time to hand the held sheet to the registration roller
  position_counter u_refeed_cnt (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(refeed_go),
    .i_tick(step_tick_reg),
    .i_target(i_refeed_steps),
    .o_done(refeed_done)
  );

  // ----------------------------------------------------------------------
  // Step divider and sensor history
  // ----------------------------------------------------------------------
  // Steps are time based since the motors give no encoder feedback
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= {`STEP_DIV_W{1'b0}};
      step_tick_reg <= 1'b0;
      exit_prev_reg <= 1'b0;
      first_prev_reg <= 1'b0;
      second_prev_reg <= 1'b0;
    end else begin
      exit_prev_reg <= i_exit_sensor;
      first_prev_reg <= i_duplex_path_sensor_first;
      second_prev_reg <= i_duplex_path_sensor_second;
      // Wrap and emit one enable pulse
      if (div_reg == STEP_CYCLES[`STEP_DIV_W-1:0] - 1'b1) begin
        div_reg <= {`STEP_DIV_W{1'b0}};
        step_tick_reg <= 1'b1;
      end else begin
        div_reg <= div_reg + 1'b1;
        step_tick_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Job mode latch
  // ----------------------------------------------------------------------
  // Length is sampled once per job so mode never changes mid-loop
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_job_active <= 1'b0;
      o_two_sheet_mode <= 1'b0;
      o_length_unsupported <= 1'b0;
    end else if (i_job_start) begin
      o_job_active <= 1'b1;
      // Length split
      // Exactly on the split length runs one sheet at a time
      o_two_sheet_mode <= i_two_sided &
        (i_sheet_len_dmm < `LEN_SPLIT_DMM);
      o_length_unsupported <= i_two_sided &
        ((i_sheet_len_dmm < `LEN_MIN_DMM) |
         (i_sheet_len_dmm > `LEN_MAX_DMM));
    end else if (i_job_end) begin
      o_job_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Exit/switchback path
  // ----------------------------------------------------------------------
  always @* begin
    ex_state_next = ex_state_reg;
    case (ex_state_reg)
      `EX_IDLE: begin
        if (exit_rise) begin
          if (i_two_sided & ~i_second_side & ~o_length_unsupported)
            ex_state_next = `EX_TO_REV;
          else
            ex_state_next = `EX_EJECT;
        end
      end
      // Forward until the trailing edge leaves the exit sensor
      `EX_EJECT: begin
        if (exit_fall)
          ex_state_next = `EX_IDLE;
      end
      // Forward toward the tray until the switchback point
      `EX_TO_REV: begin
        if (rev_done)
          ex_state_next = `EX_REVERSE;
      end
      // Roller reverses until duplex roller one has the sheet
      `EX_REVERSE: begin
        if (first_rise)
          ex_state_next = `EX_HANDOFF;
      end
      // Keep pushing until the tail clears the exit sensor
      `EX_HANDOFF: begin
        if (~i_exit_sensor)
          ex_state_next = `EX_IDLE;
      end
      default: ex_state_next = `EX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Incoming duplex transport
  // ----------------------------------------------------------------------
  always @* begin
    dp_state_next = dp_state_reg;
    case (dp_state_reg)
      `DP_IDLE: begin
        if (rev_start)
          dp_state_next = `DP_WAIT_START;
      end
      `DP_WAIT_START: begin
        if (mstart_done)
          dp_state_next = `DP_TO_FIRST;
      end
      `DP_TO_FIRST: begin
        if (first_rise)
          dp_state_next = `DP_TO_SECOND;
      end
      `DP_TO_SECOND: begin
        if (second_rise)
          dp_state_next = `DP_TO_STOP;
      end
      `DP_TO_STOP: begin
        if (stop_done)
          dp_state_next = `DP_IDLE;
      end
      default: dp_state_next = `DP_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State, hold and re-feed registers
  // ----------------------------------------------------------------------
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ex_state_reg <= `EX_IDLE;
      dp_state_reg <= `DP_IDLE;
      held_reg <= 1'b0;
      refeed_reg <= 1'b0;
    end else begin
      ex_state_reg <= ex_state_next;
      dp_state_reg <= dp_state_next;
      // Hold until re-feed time or, in two-sheet mode, the next reversal
      // A new arrival wins over the release in the same cycle
      if ((dp_state_reg == `DP_TO_STOP) & stop_done)
        held_reg <= 1'b1;
      else if (refeed_go)
        held_reg <= 1'b0;
      if (refeed_go)
        refeed_reg <= 1'b1;
      else if (refeed_done)
        refeed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Motor and status outputs
  // ----------------------------------------------------------------------
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_switchback_roller_motor_on <= 1'b0;
      o_switchback_roller_motor_reverse <= 1'b0;
      o_duplex_transport_motor_on <= 1'b0;
      o_print_even_page <= 1'b0;
      o_feed_next_sheet <= 1'b0;
      o_sheet_held <= 1'b0;
      o_refeed_started <= 1'b0;
      o_duplex_jam <= 1'b0;
    end else begin
      o_switchback_roller_motor_on <= (ex_state_next != `EX_IDLE);
      o_switchback_roller_motor_reverse <=
        (ex_state_next == `EX_REVERSE) | (ex_state_next == `EX_HANDOFF);
      o_duplex_transport_motor_on <=
        (dp_state_next == `DP_TO_FIRST) |
        (dp_state_next == `DP_TO_SECOND) |
        (dp_state_next == `DP_TO_STOP) |
        (refeed_reg & ~refeed_done) | refeed_go;
      o_print_even_page <= o_job_active & i_two_sided & ~i_second_side;
      o_feed_next_sheet <= o_two_sheet_mode & o_job_active & rev_start;
      o_sheet_held <= held_reg & ~refeed_go;
      o_refeed_started <= refeed_go;
      // Sticky until a new job; a second sheet would hit the first
      if (collide)
        o_duplex_jam <= 1'b1;
      else if (i_job_start)
        o_duplex_jam <= 1'b0;
    end
  end

endmodule // duplex_switchback_sequencer

// >>> verification/duplex_switchback_assertions.sv
`timescale 1ns/1ns
`include "duplex_switchback_map.vh"
// Watches the sequencer ports only; the set-position inputs are unused
module duplex_switchback_checker (
  // Clock, reset and job control
  input wire i_sys_clk, i_rst, i_job_start, i_job_end,
  input wire i_two_sided, i_second_side, i_refeed_time,
  input wire [`LEN_W-1:0] i_sheet_len_dmm,
  // Paper sensors
  input wire i_exit_sensor,
  input wire i_duplex_path_sensor_first, i_duplex_path_sensor_second,
  // Set positions
  input wire [`STEP_W-1:0] i_reverse_steps, i_motor_start_steps,
  input wire [`STEP_W-1:0] i_stop_steps, i_refeed_steps,
  // Motor drives and status
  input wire o_switchback_roller_motor_on, o_switchback_roller_motor_reverse,
  input wire o_duplex_transport_motor_on, o_job_active, o_two_sheet_mode,
  input wire o_length_unsupported, o_print_even_page, o_feed_next_sheet,
  input wire o_sheet_held, o_refeed_started, o_duplex_jam
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Short aliases for the motor drives
  wire sb_on = o_switchback_roller_motor_on;
  wire sb_rev = o_switchback_roller_motor_reverse;
  wire dx_on = o_duplex_transport_motor_on;
  // --------------------------------------------------------------------
  // Exit path steps
  // --------------------------------------------------------------------
  sequence arrive_s; $rose(i_exit_sensor) && !sb_on; endsequence
  sequence ejecting_s; sb_on && !sb_rev; endsequence
  sequence forward_job_s; !(i_two_sided && !i_second_side); endsequence

  chk_exit_start: assert property (arrive_s |=> sb_on)
    else $error("exit motor did not start");
  chk_single_forward: assert property (
    $rose(sb_on) and forward_job_s |-> !sb_rev [*8])
    else $error("exit motor reversed on an eject");
  chk_eject_stop: assert property (
    $fell(i_exit_sensor) and ejecting_s |-> ##[1:2] !sb_on)
    else $error("exit motor kept running after eject");
  // Reversal only with the sheet still in the exit, first side only
  chk_reverse_cause: assert property (
    $rose(sb_rev) |-> sb_on && i_exit_sensor && o_print_even_page)
    else $error("reversal without a first-side sheet");
  // --------------------------------------------------------------------
  // Duplex transport steps
  // --------------------------------------------------------------------
  chk_duplex_start: assert property (
    $rose(dx_on) && !$past(o_sheet_held) |-> sb_rev)
    else $error("duplex motor started without a reversed sheet");
  chk_first_run: assert property (
    $rose(i_duplex_path_sensor_first) && dx_on |=> dx_on && !o_sheet_held)
    else $error("duplex motor stopped at first sensor");
  chk_second_run: assert property (
    $rose(i_duplex_path_sensor_second) && dx_on |=> dx_on && !o_sheet_held)
    else $error("duplex motor stopped at second sensor");
  chk_hold_stop: assert property (
    $rose(o_sheet_held) |-> !dx_on && i_duplex_path_sensor_second)
    else $error("sheet held with motor running");
  chk_refeed_pulse: assert property (
    o_refeed_started |=> !o_refeed_started && !o_sheet_held ##[0:1] dx_on)
    else $error("re-feed did not release the sheet");
  chk_refeed_cause: assert property (
    $rose(o_refeed_started) |->
      $past(i_refeed_time) || $past(i_refeed_time, 2) || sb_rev)
    else $error("re-feed without a cause");
  chk_feed_next: assert property (
    o_feed_next_sheet |-> o_two_sheet_mode && o_job_active ##[0:1] sb_rev)
    else $error("next sheet fed outside a reversal");
  chk_mode_split: assert property (
    i_job_start && i_two_sided && i_sheet_len_dmm >= `LEN_MIN_DMM &&
      i_sheet_len_dmm <= `LEN_MAX_DMM |=> o_job_active &&
      !o_length_unsupported &&
      o_two_sheet_mode == ($past(i_sheet_len_dmm) < `LEN_SPLIT_DMM))
    else $error("wrong circulation mode");
endmodule // duplex_switchback_checker

bind duplex_switchback_sequencer duplex_switchback_checker chk_inst (.*);

// >>> verification/paper_path_model.sv
`timescale 1ns/1ns
// Moves one sheet by the motor drives and reports the sensors
module paper_path_model #(
  parameter int SHEET = 30
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_launch,
  input wire i_sb_on,
  input wire i_sb_rev,
  input wire i_dx_on,
  output reg o_exit,
  output wire o_first,
  output wire o_second
);
  int fpos, rpos, dpos;
  // Duplex position only moves while the one duplex motor runs
  assign o_first = dpos >= 4 && dpos < 14;
  assign o_second = dpos >= 20 && dpos < 36;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_exit <= 1'b0;
      fpos <= 0;
      rpos <= 0;
      dpos <= 0;
    end else begin
      if (i_dx_on) dpos <= dpos + 1;
      if (i_launch) begin
        o_exit <= 1'b1;
        fpos <= 0;
        rpos <= 0;
      end else if (o_exit && i_sb_on && !i_sb_rev) begin
        // Trailing edge clears the exit after a full forward run
        fpos <= fpos + 1;
        if (fpos == SHEET - 1) o_exit <= 1'b0;
      end else if (o_exit && i_sb_on && i_sb_rev) begin
        // Reversed sheet leaves the exit once well into the duplex path
        rpos <= rpos + 1;
        if (rpos == 19) o_exit <= 1'b0;
      end
    end
  end
endmodule // paper_path_model

// >>> verification/duplex_switchback_sequencer_bench.sv
`timescale 1ns/1ns
`include "duplex_switchback_map.vh"
module duplex_switchback_sequencer_bench;
  localparam int STEP = 4;
  localparam int SHEET = 30;
  reg i_sys_clk = 0, i_rst = 1, i_job_start = 0, i_job_end = 0;
  reg i_two_sided = 0, i_second_side = 0, i_refeed_time = 0, launch = 0;
  reg [`LEN_W-1:0] i_sheet_len_dmm = 13'h0000;
  wire exit_s, first_s, second_s;
  wire sb_on, sb_rev, dx_on, job_act, two_sheet, unsup, even, feed_nx;
  wire held, refeed, jam;
  wire [3:0] mon = {held, dx_on, sb_rev, sb_on};
  int err_count = 0, compares = 0, cyc = 0, feeds = 0, refeeds = 0;

  duplex_switchback_sequencer #(.STEP_CYCLES(STEP))
    duplex_switchback_sequencer_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_job_start(i_job_start),
    .i_job_end(i_job_end), .i_two_sided(i_two_sided),
    .i_second_side(i_second_side), .i_sheet_len_dmm(i_sheet_len_dmm),
    .i_refeed_time(i_refeed_time), .i_exit_sensor(exit_s),
    .i_duplex_path_sensor_first(first_s),
    .i_duplex_path_sensor_second(second_s),
    .i_reverse_steps(8'h03), .i_motor_start_steps(8'h02),
    .i_stop_steps(8'h02), .i_refeed_steps(8'h04),
    .o_switchback_roller_motor_on(sb_on),
    .o_switchback_roller_motor_reverse(sb_rev),
    .o_duplex_transport_motor_on(dx_on), .o_job_active(job_act),
    .o_two_sheet_mode(two_sheet), .o_length_unsupported(unsup),
    .o_print_even_page(even), .o_feed_next_sheet(feed_nx),
    .o_sheet_held(held), .o_refeed_started(refeed), .o_duplex_jam(jam));
  paper_path_model #(.SHEET(SHEET)) paper_path_model_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_launch(launch),
    .i_sb_on(sb_on), .i_sb_rev(sb_rev), .i_dx_on(dx_on),
    .o_exit(exit_s), .o_first(first_s), .o_second(second_s));

  initial forever #5 i_sys_clk = ~i_sys_clk;
  // Pulse counters and hang guard
  always @(posedge i_sys_clk) begin
    if (feed_nx === 1'b1) feeds++;
    if (refeed === 1'b1) refeeds++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi,
                             input string m);
    compares++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("unexpected at %0t: %s %0d", $time, m, got);
    end
  endtask
  // Bounded wait on one motor or hold line; n counts falling edges
  task automatic wait_mon(input int sel, input logic val, output int n);
    n = 0;
    while (mon[sel] !== val && n < 300) begin
      @(negedge i_sys_clk);
      n++;
    end
    check_bit(mon[sel], val, "wait ran out");
  endtask
  task automatic do_reset();
    i_rst = 1;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 0;
    feeds = 0;
    refeeds = 0;
    @(negedge i_sys_clk);
  endtask
  task automatic start_job(input logic two, input logic sec,
                           input logic [`LEN_W-1:0] len);
    i_two_sided = two;
    i_second_side = sec;
    i_sheet_len_dmm = len;
    i_job_start = 1;
    @(negedge i_sys_clk);
    i_job_start = 0;
    @(negedge i_sys_clk);
  endtask
  task automatic feed_sheet();
    launch = 1;
    @(negedge i_sys_clk);
    launch = 0;
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_eject(input logic two, input logic sec);
    int n, k;
    do_reset();
    start_job(two, sec, 13'h0_0BB8);
    feed_sheet();
    wait_mon(0, 1'b1, n);
    k = 0;
    while (sb_on === 1'b1 && k < 300) begin
      check_bit(sb_rev, 1'b0, "eject reversed");
      @(negedge i_sys_clk);
      k++;
    end
    check_range(k, SHEET - 1, SHEET + 3, "eject run");
    check_bit(dx_on, 1'b0, "duplex motor on eject");
    $display("eject test done");
  endtask
  task automatic t_duplex();
    int n;
    do_reset();
    start_job(1'b1, 1'b0, `LEN_SPLIT_DMM);
    check_bit(two_sheet, 1'b0, "boundary mode");
    feed_sheet();
    wait_mon(0, 1'b1, n);
    check_bit(even, 1'b1, "even page flag");
    wait_mon(1, 1'b1, n);
    check_range(n, 2 * STEP - 1, 3 * STEP + 2, "reverse point");
    wait_mon(2, 1'b1, n);
    check_range(n, STEP, 2 * STEP + 2, "motor start point");
    wait_mon(3, 1'b1, n);
    check_bit(dx_on, 1'b0, "held with motor on");
    check_bit(second_s, 1'b1, "stop point");
    repeat (20) @(negedge i_sys_clk);
    check_bit(held, 1'b1, "hold lost");
    i_refeed_time = 1;
    @(negedge i_sys_clk);
    i_refeed_time = 0;
    wait_mon(2, 1'b1, n);
    check_range(n, 0, 2, "re-feed start");
    wait_mon(2, 1'b0, n);
    check_range(n, 3 * STEP - 2, 4 * STEP + 2, "re-feed run");
    check_bit(held, 1'b0, "hold after re-feed");
    check_range(refeeds, 1, 1, "re-feed pulses");
    $display("duplex test done");
  endtask
  task automatic t_mode();
    logic [`LEN_W-1:0] lens [6] = '{13'h0_071B, 13'h0_071C, 13'h0_086E,
                                    13'h0_086F, 13'h0_10DE, 13'h0_10DF};
    do_reset();
    foreach (lens[i]) begin
      start_job(1'b1, 1'b0, lens[i]);
      check_bit(unsup, lens[i] < `LEN_MIN_DMM || lens[i] > `LEN_MAX_DMM,
                "length range");
      if (unsup === 1'b0)
        check_bit(two_sheet, lens[i] < `LEN_SPLIT_DMM, "mode");
    end
    i_job_end = 1;
    @(negedge i_sys_clk);
    i_job_end = 0;
    @(negedge i_sys_clk);
    check_bit(job_act, 1'b0, "job end");
    $display("mode test done");
  endtask
  task automatic t_two_sheet();
    int n;
    do_reset();
    start_job(1'b1, 1'b0, 13'h0_07D0);
    feed_sheet();
    wait_mon(1, 1'b1, n);
    repeat (2) @(negedge i_sys_clk);
    check_range(feeds, 1, 1, "next feed at reversal");
    wait_mon(3, 1'b1, n);
    repeat (40) @(negedge i_sys_clk);
    check_bit(held, 1'b1, "held sheet left early");
    check_range(refeeds, 0, 0, "early re-feed");
    feed_sheet();
    wait_mon(1, 1'b1, n);
    repeat (3) @(negedge i_sys_clk);
    check_range(refeeds, 1, 1, "re-feed at reversal");
    check_range(feeds, 2, 2, "second next feed");
    check_bit(jam, 1'b0, "jam while held sheet leaves");
    $display("two-sheet test done");
  endtask

  initial begin
    t_eject(1'b0, 1'b0);
    t_eject(1'b1, 1'b1);
    t_duplex();
    t_mode();
    t_two_sheet();
    conclude();
  end
endmodule // duplex_switchback_sequencer_bench
